// ### rsi_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants and types of the receive system interface
// ---------------------------------------------------------------------------
package rsi_pkg;

  // Number of line channels
  localparam int NCH = 2;
  // APB address width used by the decode
  localparam int AW = 8;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [AW-1:0] CTRL0_OFS = 8'h00;  // Channel 1 configuration
  localparam logic [AW-1:0] CTRL1_OFS = 8'h04;  // Channel 2 configuration
  localparam logic [AW-1:0] GLOBAL_OFS = 8'h08; // Global control
  localparam logic [AW-1:0] STATUS_OFS = 8'h0c; // Live status, read only

  // Global control fields
  localparam int GLB_HW_MODE_BIT = 0;  // Hardware control mode, set by register write
  localparam logic GLB_RST = 1'b0;     // Reset value of global control

  // Status layout: one nibble per channel, interrupt request on top
  localparam int STAT_STRIDE = 4;
  localparam int STAT_IRQ_BIT = 31;

  // Receive operating mode
  typedef enum logic [1:0] {
    RXM_SR_SUBST = 2'b00,  // Single rail, HDB3 or B8ZS
    RXM_SR_AMI   = 2'b01,  // Single rail, AMI
    RXM_DR_CDR   = 2'b10,  // Dual rail, clock recovery on
    RXM_SLICER   = 2'b11   // Dual rail, clock recovery bypassed
  } rsi_rxmode_t;

  // Line code handed to the decoder
  typedef enum logic [1:0] {
    CODE_AMI  = 2'b00,
    CODE_HDB3 = 2'b01,
    CODE_B8ZS = 2'b10
  } rsi_code_t;

  // Per channel configuration word, bit 0 upward from rx_mode
  typedef struct packed {
    logic mclk_ref;       // Test patterns timed from master clock
    logic auto_all_ones;  // Automatic all-ones transmission
    logic prbs_tx;        // Pseudo-random pattern transmission
    logic all_ones;       // All-ones transmission
    logic exz_report;     // Report excess zeros on violation output
    logic tclk_miss_mask; // Mask transmit clock missing interrupt
    logic alarm_signal_enable;           // Alarm indication signalling enable
    logic invert;         // Present receive data inverted
    logic fall_edge;      // Launch receive data on falling edge
    logic b8zs;           // Substitution code is B8ZS, else HDB3
    rsi_rxmode_t rx_mode; // Receive operating mode
  } rsi_chan_cfg_t;

  localparam int CFG_W = 12;
  localparam rsi_chan_cfg_t CFG_RST = 12'h000;

  // Per channel live status
  typedef struct packed {
    logic mclk_lost;     // Master clock stopped
    logic tclk_missing;  // Transmit clock stuck
    logic los;           // Received signal lost
  } rsi_chan_stat_t;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ = 50;                 // System clock rate
  localparam int TCLK_MISS_MCLK = 70;          // Stuck limit in master clocks
  localparam int TCLK_CNT_W = 8;               // Counter width for that limit
  localparam int MCLK_LOST_NS = 2000;          // Master clock silence limit
  localparam int MCLK_LOST_CYC = (MCLK_LOST_NS * CLK_MHZ) / 1000;
  localparam int MCLK_CNT_W = 8;

  // Excess zero run lengths per code
  localparam int EXZ_AMI = 16;
  localparam int EXZ_HDB3 = 4;
  localparam int EXZ_B8ZS = 8;
  localparam int ZCNT_W = 5;

  // Decoder window depth in symbols
  localparam int WIN = 8;

endpackage

// ### rsi_edge_watch.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Activity watchdog: flags a signal with no edge for more than LIMIT ticks
// ---------------------------------------------------------------------------
module rsi_edge_watch #(
  parameter int LIMIT = 70,
  parameter int CW = 8
) (
  input wire logic clk,      // System clock
  input wire logic resetn,   // Synchronous reset, active low
  input wire logic tick,     // One time unit elapsed
  input wire logic activity, // Edge seen on watched signal
  output logic missing       // Watched signal judged stuck
);

  localparam logic [CW-1:0] LIM = CW'(LIMIT);

  logic [CW-1:0] cnt_q; // Ticks since last edge
  logic missing_q;      // Registered verdict

  // Count ticks, restart on every edge, saturate past the limit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (activity) begin
      cnt_q <= '0;
    end else if (tick && (cnt_q <= LIM)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Stuck once more than the limit has passed without an edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      missing_q <= 1'b0;
    end else begin
      missing_q <= (cnt_q > LIM) && !activity;
    end
  end

  assign missing = missing_q;

endmodule

// ### rsi_line_decoder.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// AMI / HDB3 / B8ZS decoder with violation and excess zero flags
// ---------------------------------------------------------------------------
module rsi_line_decoder (
  input wire logic clk,                 // System clock
  input wire logic resetn,              // Synchronous reset, active low
  input wire logic shift,               // One received symbol
  input wire logic sym_pos,             // Positive pulse
  input wire logic sym_neg,             // Negative pulse
  input wire rsi_pkg::rsi_code_t code,  // Line code in use
  input wire logic exz_en,              // Report excess zeros
  output logic dec_data,                // Decoded bit leaving window
  output logic dec_viol                 // Violation of that bit
);

  localparam int W = rsi_pkg::WIN;

  logic [W-1:0] wp_q, wn_q, vf_q;  // Window, index 0 newest
  logic last_pol_q;                // Polarity of last pulse
  logic seen_q;                    // Any pulse seen yet
  logic [rsi_pkg::ZCNT_W-1:0] zc_q; // Zero run length
  logic [W-1:0] wp_d, wn_d, vf_d;
  logic pulse, bpv, hdb3_sub, b8zs_sub, excess_zero_event;
  logic [rsi_pkg::ZCNT_W-1:0] zlim;

  // Window update with substitution removal
  always_comb begin
    pulse = sym_pos ^ sym_neg;
    bpv = pulse && seen_q && (sym_pos == last_pol_q);
    hdb3_sub = (code == rsi_pkg::CODE_HDB3) && bpv && !wp_q[0] && !wn_q[0] && !wp_q[1] && !wn_q[1];
    unique case (code)
      rsi_pkg::CODE_HDB3: zlim = rsi_pkg::ZCNT_W'(rsi_pkg::EXZ_HDB3);
      rsi_pkg::CODE_B8ZS: zlim = rsi_pkg::ZCNT_W'(rsi_pkg::EXZ_B8ZS);
      default: zlim = rsi_pkg::ZCNT_W'(rsi_pkg::EXZ_AMI);
    endcase
    excess_zero_event = !pulse && (zc_q == zlim - 1'b1);
    wp_d = {wp_q[W-2:0], sym_pos & pulse};
    wn_d = {wn_q[W-2:0], sym_neg & pulse};
    vf_d = {vf_q[W-2:0], (bpv && !hdb3_sub) || (excess_zero_event && exz_en)};
    if (hdb3_sub) begin
      wp_d[3:0] = '0;
      wn_d[3:0] = '0;
    end
    // B8ZS pattern 000VB0VB
    b8zs_sub = (code == rsi_pkg::CODE_B8ZS) && ((wp_d[7:5] | wn_d[7:5]) == '0) && !wp_d[2] && !wn_d[2]
               && (wp_d[4] ^ wn_d[4]) && (wp_d[3] == wn_d[4]) && (wn_d[3] == wp_d[4])
               && (wp_d[1] == wp_d[3]) && (wn_d[1] == wn_d[3]) && (wp_d[0] == wp_d[4]) && (wn_d[0] == wn_d[4]);
    if (b8zs_sub) begin
      wp_d[4:0] = '0;
      wn_d[4:0] = '0;
      vf_d[4:0] = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wp_q <= '0;
      wn_q <= '0;
      vf_q <= '0;
      last_pol_q <= 1'b0;
      seen_q <= 1'b0;
      zc_q <= '0;
      dec_data <= 1'b0;
      dec_viol <= 1'b0;
    end else if (shift) begin
      wp_q <= wp_d;
      wn_q <= wn_d;
      vf_q <= vf_d;
      if (pulse) begin
        last_pol_q <= sym_pos;
        seen_q <= 1'b1;
        zc_q <= '0;
      end else if (zc_q != zlim) begin
        zc_q <= zc_q + 1'b1;
      end
      dec_data <= wp_q[W-1] | wn_q[W-1];
      dec_viol <= vf_q[W-1];
    end
  end

endmodule

// ### rsi_receive_system_interface.sv
// Overview of operation
// - Transmit clock stuck over 70 master clocks
// - Unmasked stuck transmit clock raises interrupt
// - Single rail outputs NRZ received data
// - Single rail decodes AMI, HDB3 or B8ZS
// - Violation output high one receive clock
// - Substitution codes flag code violations
// - AMI flags bipolar violations
// - Hardware mode always reports excess zeros
// - Dual rail retimed NRZ or raw RZ
// - Data launched on selectable clock edge
// - Receive data polarity selectable
// - Receive clock at line rate
// - Loss with alarm enable uses master clock
// - Recovery mode outputs recovered line clock
// - Bypass clock is XOR of rails
// - Master clock is the timing reference
// - Selected master clock times test patterns
// - Automatic all-ones and alarm use master clock
// - Hardware mode patterns use master clock
// - Master clock loss tristates line drivers
// - Loss output high while signal lost
// - Loss output clears by itself
`timescale 1ns/100ps
module rsi_receive_system_interface #(
  parameter int NCH = rsi_pkg::NCH
) (
  input wire logic clk,                      // System clock, 50 MHz
  input wire logic resetn,                   // Synchronous reset, active low
  input wire logic [rsi_pkg::AW-1:0] paddr,  // APB address
  input wire logic psel,                     // APB select
  input wire logic penable,                  // APB enable
  input wire logic pwrite,                   // APB direction
  input wire logic [31:0] pwdata,            // APB write data
  output logic [31:0] prdata,                // APB read data
  output logic pready,                       // APB ready
  output logic pslverr,                      // APB error
  input wire logic mclk,                     // Master clock pin
  input wire logic [NCH-1:0] tx_clock_in,    // Transmit clock pins
  input wire logic [NCH-1:0] rx_rec_clk,     // Clock from recovery unit
  input wire logic [NCH-1:0] rx_slice_pos,   // Positive slicer output
  input wire logic [NCH-1:0] rx_slice_neg,   // Negative slicer output
  input wire logic [NCH-1:0] los_detect,     // Loss detector verdict
  output logic [NCH-1:0] rx_nrz_data,        // Data, or positive rail
  output logic [NCH-1:0] rx_violation_flag,  // Violation, or negative rail
  output logic [NCH-1:0] rx_clock_out,       // Receive clock
  output logic [NCH-1:0] signal_lost_out,    // Loss of signal
  output logic [NCH-1:0] tx_line_oe,         // Line driver enable
  output logic [NCH-1:0] tx_ref_tick,        // Transmit timing tick
  output logic irq                           // Interrupt request
);

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  localparam int SW = 1 + 5 * NCH;

  logic [SW-1:0] sync_in;  // Raw pin vector
  logic [SW-1:0] s1_q;     // First stage, read only by s2
  logic [SW-1:0] s2_q;     // Second stage, safe to use
  logic [SW-1:0] s3_q;     // Delayed copy for edge detection

  assign sync_in = {mclk, tx_clock_in, rx_rec_clk, rx_slice_pos, rx_slice_neg, los_detect};

  // Two flop synchroniser plus edge history
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= sync_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Field views of the synchronised vector
  logic mclk_s, mclk_rise;
  logic [NCH-1:0] tclk_s, tclk_edge, tclk_rise, rec_s, pos_s, neg_s, los_s;

  assign mclk_s = s2_q[SW-1];
  assign mclk_rise = s2_q[SW-1] & ~s3_q[SW-1];
  assign tclk_s = s2_q[5*NCH-1 -: NCH];
  assign tclk_edge = s2_q[5*NCH-1 -: NCH] ^ s3_q[5*NCH-1 -: NCH];
  assign tclk_rise = s2_q[5*NCH-1 -: NCH] & ~s3_q[5*NCH-1 -: NCH];
  assign rec_s = s2_q[4*NCH-1 -: NCH];
  assign pos_s = s2_q[3*NCH-1 -: NCH];
  assign neg_s = s2_q[2*NCH-1 -: NCH];
  assign los_s = s2_q[NCH-1 -: NCH];

  // ---------------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------------
  rsi_pkg::rsi_chan_cfg_t ctrl_q [NCH];  // Per channel configuration
  logic hw_mode_q;                       // Hardware control mode
  rsi_pkg::rsi_chan_stat_t stat [NCH];   // Per channel live status
  logic [NCH-1:0] irq_src;               // Unmasked stuck clocks
  logic wr_en, rd_en, addr_ok;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign addr_ok = (paddr == rsi_pkg::CTRL0_OFS) || (paddr == rsi_pkg::CTRL1_OFS) ||
                   (paddr == rsi_pkg::GLOBAL_OFS) || (paddr == rsi_pkg::STATUS_OFS);

  // Zero wait slave
  assign pready = 1'b1;
  // Unmapped addresses answer with an error
  assign pslverr = psel & penable & ~addr_ok;

  // Configuration writes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_q[c] <= rsi_pkg::CFG_RST;
      end
    end else if (wr_en) begin
      if (paddr == rsi_pkg::CTRL0_OFS) begin
        ctrl_q[0] <= pwdata[rsi_pkg::CFG_W-1:0];
      end
      if (paddr == rsi_pkg::CTRL1_OFS) begin
        ctrl_q[1] <= pwdata[rsi_pkg::CFG_W-1:0];
      end
    end
  end

  // Global control write
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hw_mode_q <= rsi_pkg::GLB_RST;
    end else if (wr_en && (paddr == rsi_pkg::GLOBAL_OFS)) begin
      hw_mode_q <= pwdata[rsi_pkg::GLB_HW_MODE_BIT];
    end
  end

  // Read multiplexer
  always_comb begin
    prdata = '0;
    if (rd_en) begin
      unique case (paddr)
        rsi_pkg::CTRL0_OFS: prdata[rsi_pkg::CFG_W-1:0] = ctrl_q[0];
        rsi_pkg::CTRL1_OFS: prdata[rsi_pkg::CFG_W-1:0] = ctrl_q[1];
        rsi_pkg::GLOBAL_OFS: prdata[rsi_pkg::GLB_HW_MODE_BIT] = hw_mode_q;
        rsi_pkg::STATUS_OFS: begin
          for (int c = 0; c < NCH; c++) begin
            prdata[c*rsi_pkg::STAT_STRIDE +: 3] = stat[c];
          end
          prdata[rsi_pkg::STAT_IRQ_BIT] = irq;
        end
        default: prdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Master clock watchdog
  // ---------------------------------------------------------------------------
  logic mclk_lost;  // No master clock edge for too long

  rsi_edge_watch #(
    .LIMIT(rsi_pkg::MCLK_LOST_CYC),
    .CW(rsi_pkg::MCLK_CNT_W)
  ) u_mclk_watch (
    .clk(clk),
    .resetn(resetn),
    .tick(1'b1),
    .activity(mclk_rise),
    .missing(mclk_lost)
  );

  assign irq = |irq_src;

  // ---------------------------------------------------------------------------
  // Per channel datapath
  // ---------------------------------------------------------------------------
  // independent channels
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    rsi_pkg::rsi_chan_cfg_t cfg;
    logic single_rail, slicer, ais_clk, src_clk, act_edge;
    logic rck_q, d0_q, d1_q, los_q, tick_q, oe_q;
    logic tclk_missing, mclk_timed, dec_data, dec_viol;
    rsi_pkg::rsi_code_t code;

    assign cfg = ctrl_q[i];
    assign single_rail = ~cfg.rx_mode[1];
    assign slicer = (cfg.rx_mode == rsi_pkg::RXM_SLICER);
    assign ais_clk = los_s[i] & cfg.alarm_signal_enable;

    // Receive clock source selection
    always_comb begin
      if (ais_clk) begin
        src_clk = mclk_s;
      end else if (slicer) begin
        src_clk = pos_s[i] ^ neg_s[i];
      end else begin
        src_clk = rec_s[i];
      end
    end

    assign act_edge = cfg.fall_edge ? (rck_q & ~src_clk) : (~rck_q & src_clk);

    // Registered receive clock output
    always_ff @(posedge clk) begin
      if (!resetn) begin
        rck_q <= 1'b0;
      end else begin
        rck_q <= src_clk;
      end
    end

    // Decoder code choice
    always_comb begin
      if (cfg.rx_mode == rsi_pkg::RXM_SR_AMI) begin
        code = rsi_pkg::CODE_AMI;
      end else if (cfg.b8zs) begin
        code = rsi_pkg::CODE_B8ZS;
      end else begin
        code = rsi_pkg::CODE_HDB3;
      end
    end

    // Line decoder, one symbol per active edge
    rsi_line_decoder u_dec (
      .clk(clk),
      .resetn(resetn),
      .shift(act_edge & single_rail & ~ais_clk),
      .sym_pos(pos_s[i]),
      .sym_neg(neg_s[i]),
      .code(code),
      .exz_en(hw_mode_q | cfg.exz_report),
      .dec_data(dec_data),
      .dec_viol(dec_viol)
    );

    // Output data, launched together with the clock edge
    always_ff @(posedge clk) begin
      if (!resetn) begin
        d0_q <= 1'b0;
        d1_q <= 1'b0;
      end else if (slicer && !ais_clk) begin
        d0_q <= pos_s[i] ^ cfg.invert;
        d1_q <= neg_s[i] ^ cfg.invert;
      end else if (act_edge) begin
        if (ais_clk) begin
          // Alarm indication: all ones
          d0_q <= ~cfg.invert;
          d1_q <= single_rail ? 1'b0 : cfg.invert;
        end else if (single_rail) begin
          d0_q <= dec_data ^ cfg.invert;
          d1_q <= dec_viol;
        end else begin
          d0_q <= pos_s[i] ^ cfg.invert;
          d1_q <= neg_s[i] ^ cfg.invert;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!resetn) begin
        los_q <= 1'b0;
      end else begin
        los_q <= los_s[i];
      end
    end

    rsi_edge_watch #(
      .LIMIT(rsi_pkg::TCLK_MISS_MCLK),
      .CW(rsi_pkg::TCLK_CNT_W)
    ) u_tclk_watch (
      .clk(clk),
      .resetn(resetn),
      .tick(mclk_rise),
      .activity(tclk_edge[i]),
      .missing(tclk_missing)
    );

    assign mclk_timed = cfg.auto_all_ones | ais_clk | ((cfg.mclk_ref | hw_mode_q) & (cfg.all_ones | cfg.prbs_tx));

    // Transmit timing tick from chosen reference
    always_ff @(posedge clk) begin
      if (!resetn) begin
        tick_q <= 1'b0;
      end else begin
        tick_q <= mclk_timed ? mclk_rise : tclk_rise[i];
      end
    end

    always_ff @(posedge clk) begin
      if (!resetn) begin
        oe_q <= 1'b0;
      end else begin
        oe_q <= ~mclk_lost;
      end
    end

    assign stat[i] = '{mclk_lost: mclk_lost, tclk_missing: tclk_missing, los: los_q};
    assign irq_src[i] = tclk_missing & ~cfg.tclk_miss_mask;
    assign rx_nrz_data[i] = d0_q;
    assign rx_violation_flag[i] = d1_q;
    assign rx_clock_out[i] = rck_q;
    assign signal_lost_out[i] = los_q;
    assign tx_line_oe[i] = oe_q;
    assign tx_ref_tick[i] = tick_q;
  end

endmodule

// ### rsi_rx_checker.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checker of the receive interface
// ----------------------------------------
module rsi_rx_checker #(
  parameter int NCH = 2
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [rsi_pkg::AW-1:0] paddr, // APB address
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic mclk, // Master clock pin
  input wire logic [NCH-1:0] tx_clock_in, // Transmit clocks
  input wire logic [NCH-1:0] los_detect, // Loss verdicts
  input wire logic [NCH-1:0] signal_lost_out, // Loss outputs
  input wire logic [NCH-1:0] rx_violation_flag, // Violation outputs
  input wire logic [NCH-1:0] rx_clock_out, // Receive clocks
  input wire logic [NCH-1:0] tx_line_oe, // Driver enables
  input wire logic irq // Interrupt request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [9:0] tq_q; // Cycles since a transmit clock change
  logic [9:0] mq_q; // Cycles since a master clock change
  logic dr_q; // First channel set to dual rail
  // ----------------------------------------
  // Quiet time counters, saturating
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tq_q <= 10'h000;
      mq_q <= 10'h000;
      dr_q <= 1'b0;
    end else begin
      tq_q <= $changed(tx_clock_in) ? 10'h000 : tq_q + {9'h000, ~&tq_q};
      mq_q <= $changed(mclk) ? 10'h000 : mq_q + {9'h000, ~&mq_q};
      if (psel && penable && pwrite && paddr == 8'h00) begin
        dr_q <= pwdata[1];
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rdy; psel && penable |-> pready && (pslverr == (paddr > 8'h0c || |paddr[1:0])); endproperty
  a_rdy: assert property (p_rdy) else $error("access answer wrong");
  property p_rdz; !(psel && penable) |-> prdata == 32'h0000_0000 && !pslverr; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside access");
  property p_los_set; los_detect[0] [*5] |-> signal_lost_out[0]; endproperty
  a_los_set: assert property (p_los_set) else $error("loss output not raised");
  property p_los_clr; (!los_detect[0]) [*5] |-> !signal_lost_out[0]; endproperty
  a_los_clr: assert property (p_los_clr) else $error("loss output not cleared");
  // Seventy master clocks at six system clocks, less sync slack
  property p_miss; $rose(irq) |-> tq_q > 10'h190; endproperty
  a_miss: assert property (p_miss) else $error("stuck clock flagged early");
  property p_oe; mq_q > 10'h078 |-> tx_line_oe == '0; endproperty
  a_oe: assert property (p_oe) else $error("drivers on without master clock");
  property p_oe_keep; $fell(tx_line_oe[0]) |-> mq_q > 10'h050; endproperty
  a_oe_keep: assert property (p_oe_keep) else $error("drivers off with master clock");
  property p_viol; !dr_q && $changed(rx_violation_flag[0]) |-> $changed(rx_clock_out[0]); endproperty
  a_viol: assert property (p_viol) else $error("violation moved off clock edge");
  c_irq: cover property ($rose(irq));
  c_viol: cover property ($rose(rx_violation_flag[0]));
  c_los: cover property ($rose(signal_lost_out[0]));
endmodule

bind rsi_receive_system_interface rsi_rx_checker #(.NCH(NCH)) chk_u (.clk(clk), .resetn(resetn), .psel(psel),
  .pwrite(pwrite), .pwdata(pwdata),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mclk(mclk),
  .tx_clock_in(tx_clock_in), .los_detect(los_detect), .signal_lost_out(signal_lost_out),
  .rx_violation_flag(rx_violation_flag), .rx_clock_out(rx_clock_out), .tx_line_oe(tx_line_oe), .irq(irq));

// ### rsi_framer_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Framer side: transmit clock and capture
// ----------------------------------------
module rsi_framer_model (
  input wire logic run, // Transmit clock enable
  input wire logic rclk, // Receive clock, first channel
  input wire logic rdata, // Receive data, first channel
  input wire logic rviol, // Violation flag, first channel
  output logic tclk, // Transmit clock
  output logic [23:0] hist, // Captured bits, newest at bit 0
  output logic [7:0] nviol // Violations seen
);
  initial tclk = 1'b0;
  initial hist = 24'h00_0000;
  initial nviol = 8'h00;
  // Transmit clock stands still while run is low
  always #80 if (run) tclk = ~tclk;
  // Capture mid bit, away from the launching edge
  always @(negedge rclk) begin
    hist <= {hist[22:0], rdata};
    nviol <= nviol + {7'h00, rviol};
  end
endmodule

// ### rsi_receive_system_interface_tb.sv
`timescale 1ns/100ps
// ----------------------------------------
// Bench of the receive interface
// ----------------------------------------
module rsi_receive_system_interface_tb;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mclk = 1'b0, rclk = 1'b0;
  logic mrun = 1'b1, trun = 1'b1, er, f, tclk, pready, pslverr, irq; // Enables and flags
  logic [7:0] paddr = 8'h00, nviol, v0; // Address and counts
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, nt = 32'h0000_0000, t0; // Data words
  logic [1:0] pos = 2'b00, neg = 2'b00, los = 2'b00, dat, vio, rco, lost, oe, tk; // Channel lines
  logic [23:0] hist; // Captured stream
  int num_errors = 0, compares = 0;
  always #10 clk = ~clk;
  // Master clock, six system clocks a period
  always #60 if (mrun) mclk = ~mclk;
  // Recovered line clock, phase unrelated to clk
  initial #7 forever #80 rclk = ~rclk;
  always @(posedge clk) nt <= nt + 32'(tk[0]); // First channel ticks
  rsi_receive_system_interface dut_u (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mclk(mclk),
    .tx_clock_in({2{tclk}}), .rx_rec_clk({2{rclk}}), .rx_slice_pos(pos), .rx_slice_neg(neg), .los_detect(los),
    .rx_nrz_data(dat), .rx_violation_flag(vio), .rx_clock_out(rco), .signal_lost_out(lost), .tx_line_oe(oe),
    .tx_ref_tick(tk), .irq(irq));
  rsi_framer_model far_u (.run(trun), .rclk(rco[0]), .rdata(dat[0]), .rviol(vio[0]), .tclk(tclk), .hist(hist),
    .nviol(nviol));
  // Count a comparison, report a mismatch
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer, waits for ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One line symbol, changed after the line clock falls
  task automatic sym(input logic p, input logic n);
    @(negedge rclk);
    @(posedge clk);
    pos[0] <= p;
    neg[0] <= n;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
  // Codes per run: AMI, HDB3, B8ZS, AMI inverted
  logic [31:0] cfg [4] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0004, 32'h0000_0011};
  logic [7:0] pat [4] = '{8'hb1, 8'hb0, 8'hb1, 8'h4e};
  logic [7:0] ev [4] = '{8'h01, 8'h00, 8'h01, 8'h01};
  logic [7:0] mk = 8'hb1, pl = 8'h91; // Mark places and signs
  logic [1:0] sl [4] = '{2'b10, 2'b11, 2'b01, 2'b00}; // Rail pairs
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("ctrl0 reset", 32'h0000_0000, rd);
    apb(1'b1, 8'h04, 32'h0000_0fff);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("ctrl1", 32'h0000_0fff, rd);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, 32'(er));
    $display("test registers done");
    los <= 2'b01;
    cyc(8);
    chk("loss out", 32'h0000_0001, 32'(lost));
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk("status", 32'h0000_0001, 32'(rd[6:0]));
    los <= 2'b00;
    cyc(8);
    chk("loss clear", 32'h0000_0000, 32'(lost));
    $display("test loss done");
    // Signs flip each run so AMI stays balanced across runs
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 8'h00, cfg[k]);
      v0 = nviol;
      repeat (4) sym(1'b0, 1'b0);
      for (int i = 7; i >= 0; i--) sym(mk[i] & (pl[i] ^ k[0]), mk[i] & ~(pl[i] ^ k[0]));
      repeat (12) sym(1'b0, 1'b0);
      f = 1'b0;
      for (int j = 0; j <= 16; j++) if (hist[j+:8] === pat[k]) f = 1'b1;
      chk("decoded bits", 32'h0000_0001, 32'(f));
      chk("violations", 32'(ev[k]), 32'(nviol - v0));
    end
    $display("test codes done");
    apb(1'b1, 8'h00, 32'h0000_0003);
    for (int i = 0; i < 4; i++) begin
      pos[0] <= sl[i][1];
      neg[0] <= sl[i][0];
      cyc(6);
      chk("slicer", 32'({sl[i], ^sl[i]}), 32'({dat[0], vio[0], rco[0]}));
    end
    $display("test slicer done");
    trun <= 1'b0;
    cyc(300);
    chk("irq early", 32'h0000_0000, 32'(irq));
    cyc(200);
    chk("irq late", 32'h0000_0001, 32'(irq));
    apb(1'b1, 8'h00, 32'h0000_0443);
    cyc(2);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    t0 = nt;
    cyc(60);
    chk("mclk ticks", 32'h0000_000a, nt - t0);
    trun <= 1'b1;
    cyc(20);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk("clock back", 32'h0000_0000, 32'(rd[1]));
    chk("drivers on", 32'h0000_0003, 32'(oe));
    mrun <= 1'b0;
    cyc(150);
    chk("drivers off", 32'h0000_0000, 32'(oe));
    mrun <= 1'b1;
    cyc(20);
    chk("drivers back", 32'h0000_0003, 32'(oe));
    $display("test clocks done");
    summarize();
  end
endmodule
